// ### bench/ext_bus_if_tb.sv
// self-checking bench for the external bus interface
`timescale 1ns/100ps
module ext_bus_if_tb;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b1;
  logic poll_n = 1'b1;
  ext_bus_pkg::core_req_s req = '0;
  logic [15:0] bus, dq, oe_n, periph, rd;
  logic [11:0] addr;
  ext_bus_pkg::strobes_s stb;
  logic rv, busy;
  int bad_count = 0;
  int comparisons = 0;
  always #12.5 mclk_in = ~mclk_in;
  assign bus = (oe_n === 16'h0000) ? dq : periph;
  ext_bus_if i_dut(.mclk_in(mclk_in), .resetn_in(resetn_in), .req_in(req),
    .poll_input_n_in(poll_n), .data_in(bus), .address_out(addr), .data_out(dq),
    .data_oe_n_out(oe_n), .strobes_out(stb), .read_data_out(rd), .read_valid_out(rv),
    .busy_out(busy));
  port_peripheral i_periph(.mclk_in(mclk_in), .strobes_in(stb), .address_in(addr),
    .data_out(periph));
  // ****************
  // helpers
  // ****************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic idle;
    for (int i = 0; i < 20 && busy !== 1'b0; i++)
      @(posedge mclk_in) #1;
    if (busy !== 1'b0)
    begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic go(input ext_bus_pkg::op_e op, input logic [2:0] p, input logic [15:0] w,
    input logic poll);
    idle();
    @(posedge mclk_in);
    req <= '{1'b1, op, 12'h0a5, p, w, 12'h3c7};
    poll_n <= poll;
    @(posedge mclk_in);
    req.valid <= 1'b0;
    #1;
  endtask
  task automatic rst;
    @(posedge mclk_in);
    resetn_in <= 1'b0;
    repeat (5) @(posedge mclk_in);
    #1;
    check(addr, 12'h000);
    check(stb, 3'b111);
    check(oe_n, 16'hffff);
    @(posedge mclk_in);
    resetn_in <= 1'b1;
    #1;
    idle();
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_ports;
    for (int p = 0; p < 8; p++)
    begin
      go(ext_bus_pkg::op_in, p[2:0], 16'h0000, 1'b1);
      check(addr, {9'h000, p[2:0]});
      check(stb, 3'b110);
      check(oe_n, 16'hffff);
      @(posedge mclk_in) #1;
      check({rv, rd}, {1'b1, 4'h5, 9'h000, p[2:0]});
      go(ext_bus_pkg::op_out, p[2:0], 16'hbee0 ^ p, 1'b1);
      check(addr, {9'h000, p[2:0]});
      check(stb, 3'b101);
      check({oe_n, dq}, {16'h0000, 16'hbee0 ^ p[15:0]});
      @(posedge mclk_in) #1;
      check(stb, 3'b011);
    end
  endtask
  task automatic t_table;
    go(ext_bus_pkg::op_table_write, 3'h0, 16'h1234, 1'b1);
    check({busy, stb, addr}, {1'b1, 3'b011, 12'h3c7});
    @(posedge mclk_in) #1;
    check({stb, oe_n, dq}, {3'b101, 16'h0000, 16'h1234});
  endtask
  task automatic t_poll;
    go(ext_bus_pkg::op_branch_on_poll, 3'h0, 16'h0000, 1'b0);
    @(posedge mclk_in) #1;
    check(addr, 12'h0a5);
    go(ext_bus_pkg::op_branch_on_poll, 3'h0, 16'h0000, 1'b1);
    @(posedge mclk_in) #1;
    check(addr === 12'h0a5, 1'b0);
  endtask
  initial
  begin
    // a real falling edge at time zero, so the asynchronous reset is seen
    resetn_in <= 1'b0;
    rst();
    t_ports();
    t_table();
    t_poll();
    rst();
    t_poll();
    finish_test();
  end
endmodule

// ### bench/ext_bus_monitor.sv
// port assertions for the external bus interface
`timescale 1ns/100ps
module ext_bus_monitor
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire ext_bus_pkg::core_req_s req_in,
  input wire logic poll_input_n_in,
  input wire logic [11:0] address_out,
  input wire logic [15:0] data_oe_n_out,
  input wire ext_bus_pkg::strobes_s strobes_out,
  input wire logic read_valid_out,
  input wire logic busy_out
);
  // ****************
  // checks
  // ****************
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  wire [2:0] s = strobes_out;
  wire take = req_in.valid && !busy_out;
  a_in_alone: assert property (!s[0] |-> s[2:1] == 2'b11)
    else $error("strobe low beside input strobe");
  a_wr_alone: assert property (!s[1] |-> {s[2], s[0]} == 2'b11)
    else $error("strobe low beside write strobe");
  a_fetch_else: assert property (s[1] && s[0] && !busy_out |-> !s[2])
    else $error("fetch strobe missing");
  a_bus_drive: assert property (data_oe_n_out == {16{s[1]}})
    else $error("bus enable differs from write strobe");
  a_out_port: assert property (take && req_in.op == ext_bus_pkg::op_out
    |=> address_out == {9'h000, $past(req_in.port)} && !s[1])
    else $error("port output cycle wrong");
  a_in_port: assert property (take && req_in.op == ext_bus_pkg::op_in
    |=> address_out == {9'h000, $past(req_in.port)} && !s[0] ##1 s[0] && read_valid_out)
    else $error("port input cycle wrong");
  a_tw_second: assert property (take && req_in.op == ext_bus_pkg::op_table_write
    |=> busy_out && s[1] ##1 !s[1])
    else $error("table write strobe misplaced");
  a_poll_branch: assert property (take && req_in.op == ext_bus_pkg::op_branch_on_poll
    && !poll_input_n_in |=> ##1 address_out == $past(req_in.target, 2))
    else $error("branch on poll not taken");
  a_reset_quiet: assert property (disable iff (1'b0)
    !resetn_in [*2] |-> s == 3'b111 && address_out == 12'h000)
    else $error("outputs not quiet in reset");
  cover property (!s[0] ##1 read_valid_out);
  cover property (!s[1] && busy_out);
  cover property (take && req_in.op == ext_bus_pkg::op_branch_on_poll && !poll_input_n_in);
endmodule
bind ext_bus_if ext_bus_monitor i_mon(.mclk_in(mclk_in), .resetn_in(resetn_in),
  .req_in(req_in), .poll_input_n_in(poll_input_n_in), .address_out(address_out),
  .data_oe_n_out(data_oe_n_out), .strobes_out(strobes_out),
  .read_valid_out(read_valid_out), .busy_out(busy_out));

// ### bench/port_peripheral.sv
// behavioural port peripheral on the data bus
`timescale 1ns/100ps
module port_peripheral
(
  input wire logic mclk_in,
  input wire ext_bus_pkg::strobes_s strobes_in,
  input wire logic [11:0] address_in,
  output logic [15:0] data_out
);
  logic [15:0] last_reg = 16'h0000;
  // released bus changes every cycle so stale data never passes for an answer
  assign data_out = strobes_in.input_data_strobe_n ? ~last_reg : {4'h5, address_in};
  always @(posedge mclk_in)
    last_reg <= data_out;
endmodule

// ### design/bus_cycle_seq.sv
// two-cycle sequencer for instructions that occupy the bus twice
`timescale 1ns/100ps
module bus_cycle_seq
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  output logic second_cycle_out
);
  typedef struct packed {
    logic second;
  } seq_state_s;

  seq_state_s state_reg;
  seq_state_s state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.second = start_in && !state_reg.second;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign second_cycle_out = state_reg.second;
endmodule

// ### design/ext_bus_if.sv
// external program/port bus interface of the signal processor
// Notes on behaviour
// - address lines always driven, never floated
// - port number on three low address lines
// - upper nine address lines low on port access
// - data bus driven only while write strobe low
// - branch-on-poll taken when poll input low, unless requested while input or write strobe low
// - input strobe first cycle of port input
// - input strobe low keeps write, fetch high
// - write strobe: port output, table-write second cycle
// - fetch strobe low on all other cycles, except in reset and the first cycle after its release
// - reset five cycles: strobes high, bus released, clear
`timescale 1ns/100ps
module ext_bus_if
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire ext_bus_pkg::core_req_s req_in,
  input wire logic poll_input_n_in,
  input wire logic [15:0] data_in,
  output logic [11:0] address_out,
  output logic [15:0] data_out,
  output logic [15:0] data_oe_n_out,
  output ext_bus_pkg::strobes_s strobes_out,
  output logic [15:0] read_data_out,
  output logic read_valid_out,
  output logic busy_out
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {
    st_reset = 3'h1,
    st_run = 3'h2,
    st_table = 3'h4
  } phase_e;

  typedef struct packed {
    phase_e phase;
    logic [11:0] pc;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic drive;
    ext_bus_pkg::strobes_s strobes;
    logic [15:0] rdata;
    logic rvalid;
  } bus_state_s;

  bus_state_s state_reg;
  bus_state_s state_next;
  // kept apart from the state struct: it alone is reset by the raw pin
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic second_cycle;
  logic table_start;

  // reset released through two flops; the first is seen only by the second
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_n = rst_sync_reg[1];

  function automatic logic [11:0] port_address(input logic [2:0] port);
    port_address = {9'h000, port};
  endfunction

  assign table_start = (state_reg.phase == st_run) && req_in.valid
    && (req_in.op == ext_bus_pkg::op_table_write);

  bus_cycle_seq u_seq
  (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n),
    .start_in(table_start),
    .second_cycle_out(second_cycle)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    state_next.drive = 1'b0;
    state_next.strobes = '{fetch_strobe_n: 1'b0, write_strobe_n: 1'b1,
      input_data_strobe_n: 1'b1};
    unique case (state_reg.phase)
      st_reset:
      begin
        // clear one full cycle after release
        state_next.pc = ext_bus_pkg::pc_reset_value;
        state_next.addr = ext_bus_pkg::pc_reset_value;
        state_next.phase = st_run;
      end
      st_run:
      begin
        state_next.addr = state_reg.pc;
        if (req_in.valid)
        begin
          unique case (req_in.op)
            ext_bus_pkg::op_in:
            begin
              state_next.addr = port_address(req_in.port);
              state_next.strobes = '{fetch_strobe_n: 1'b1, write_strobe_n: 1'b1,
                input_data_strobe_n: 1'b0};
            end
            ext_bus_pkg::op_out:
            begin
              state_next.addr = port_address(req_in.port);
              state_next.wdata = req_in.wdata;
              state_next.drive = 1'b1;
              state_next.strobes = '{fetch_strobe_n: 1'b1, write_strobe_n: 1'b0,
                input_data_strobe_n: 1'b1};
            end
            ext_bus_pkg::op_table_write:
            begin
              state_next.addr = req_in.table_addr;
              state_next.wdata = req_in.wdata;
              state_next.phase = st_table;
            end
            ext_bus_pkg::op_branch_on_poll:
            begin
              if (!poll_input_n_in)
                state_next.pc = req_in.target;
              else
                state_next.pc = state_reg.pc + 12'h001;
            end
            ext_bus_pkg::op_jump:
              state_next.pc = req_in.target;
            default:
              state_next.pc = state_reg.pc + 12'h001;
          endcase
        end
      end
      st_table:
      begin
        // second cycle of table write: write strobe, fetch held high
        state_next.drive = 1'b1;
        state_next.strobes = '{fetch_strobe_n: 1'b1, write_strobe_n: 1'b0,
          input_data_strobe_n: 1'b1};
        state_next.pc = state_reg.pc + 12'h001;
        state_next.phase = st_run;
      end
      default:
        state_next.phase = st_reset;
    endcase
    // data is taken at the end of the input strobe cycle
    if (!state_reg.strobes.input_data_strobe_n)
    begin
      state_next.rdata = data_in;
      state_next.rvalid = 1'b1;
      state_next.pc = state_reg.pc + 12'h001;
    end
    if (!state_reg.strobes.write_strobe_n && state_reg.phase == st_run)
      state_next.pc = state_reg.pc + 12'h001;
  end

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg.phase <= st_reset;
      state_reg.pc <= ext_bus_pkg::pc_reset_value;
      state_reg.addr <= ext_bus_pkg::pc_reset_value;
      state_reg.wdata <= 16'h0000;
      state_reg.drive <= 1'b0;
      state_reg.strobes <= 3'h7;
      state_reg.rdata <= 16'h0000;
      state_reg.rvalid <= 1'b0;
    end
    else
    begin
      state_reg.phase <= state_next.phase;
      state_reg.pc <= state_next.pc;
      state_reg.addr <= state_next.addr;
      state_reg.wdata <= state_next.wdata;
      state_reg.drive <= state_next.drive;
      state_reg.strobes <= state_next.strobes;
      state_reg.rdata <= state_next.rdata;
      state_reg.rvalid <= state_next.rvalid;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign address_out = state_reg.addr;
  assign data_out = state_reg.wdata;
  // enable active low, from the drive flop, which is set together with the write strobe so they never disagree
  assign data_oe_n_out = {16{~state_reg.drive}};
  assign strobes_out = state_reg.strobes;
  assign read_data_out = state_reg.rdata;
  assign read_valid_out = state_reg.rvalid;
  assign busy_out = (state_reg.phase != st_run) || second_cycle;
endmodule

// ### design/ext_bus_pkg.sv
// shared constants and carrier types for the external bus interface
package ext_bus_pkg;
  localparam int addr_width = 12;
  localparam int data_width = 16;
  localparam int port_width = 3;
  localparam int port_number_lsb = 0;
  localparam int port_number_msb = 2;
  localparam int address_bit_three = 3;
  localparam int address_msb = 11;
  localparam int address_lsb = 0;
  localparam int reset_hold_cycles = 5;
  localparam logic [11:0] pc_reset_value = 12'h000;

  typedef enum logic [5:0] {
    op_seq = 6'h01,
    op_in = 6'h02,
    op_out = 6'h04,
    op_table_write = 6'h08,
    op_branch_on_poll = 6'h10,
    op_jump = 6'h20
  } op_e;

  // one request from the execution core per machine cycle
  typedef struct packed {
    logic valid;
    op_e op;
    logic [11:0] target;
    logic [2:0] port;
    logic [15:0] wdata;
    logic [11:0] table_addr;
  } core_req_s;

  // strobes are active low
  typedef struct packed {
    logic fetch_strobe_n;
    logic write_strobe_n;
    logic input_data_strobe_n;
  } strobes_s;
endpackage
